// ===== rtl/lsd_gate_if.sv
// Purpose: Carries sampled gate and strobe levels between blocks
// Assumes: Single clock
// Notes:   Producer is the mode unit, consumer the main datapath
`timescale 1ns/10ps
`default_nettype none
interface lsd_gate_if;
  logic gate_low;
  logic strobe;
  logic special;
  logic switching;
  modport prod (output gate_low, output strobe, output special,
                output switching);
  modport cons (input gate_low, input strobe, input special,
                input switching);
endinterface : lsd_gate_if
`default_nettype wire

// ===== rtl/lsd_mode.sv
// Purpose: Detects the gate pulse and steps through mode switching
// Assumes: Gate and strobe already synchronised
// Notes:   Edge count starts at the first high of the pulse
`timescale 1ns/10ps
`default_nettype none
`include "lsd_params.svh"
module lsd_mode
  import lsd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // Sampled pins
  input  wire logic gate_s,
  input  wire logic strobe_s,
  // To datapath
  lsd_gate_if.prod  gif
);
  lsd_mode_t mode;
  lsd_mode_t next_mode;
  logic      sel_special;
  logic      next_sel_special;
  logic      ph;
  logic      next_ph;
  logic [1:0] hist;
  logic [1:0] next_hist;
  logic      pulse;

  // Pattern high, low, high on three edges
  assign pulse = hist[1] & ~hist[0] & gate_s;

  always_comb begin
    next_hist        = hist;
    next_mode        = mode;
    next_sel_special = sel_special;
    next_ph          = ph;
    if (clk_en) begin
      next_hist = {hist[0], gate_s};
      unique case (mode)
        LSD_NORMAL, LSD_SPECIAL: begin
          if (pulse) begin
            next_mode = LSD_SWITCH;
            next_ph   = 1'b0;
            next_sel_special = (mode == LSD_SPECIAL);
          end
        end
        LSD_SWITCH: begin
          next_ph = 1'b1;
          if (!ph) begin
            next_sel_special = strobe_s;
          end else begin
            next_mode = sel_special ? LSD_SPECIAL : LSD_NORMAL;
          end
        end
        default: next_mode = LSD_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode        <= LSD_NORMAL;
      sel_special <= 1'b0;
      ph          <= 1'b0;
      hist        <= 2'b11;
    end else begin
      mode        <= next_mode;
      sel_special <= next_sel_special;
      ph          <= next_ph;
      hist        <= next_hist;
    end
  end

  assign gif.gate_low  = ~gate_s;
  assign gif.strobe    = strobe_s;
  assign gif.special   = (mode == LSD_SPECIAL);
  assign gif.switching = (mode == LSD_SWITCH) | pulse;
endmodule : lsd_mode
`default_nettype wire

// ===== rtl/lsd_params.svh
// Purpose: Constants for the LED sink driver serial control logic
// Assumes: One serial clock domain, active-low asynchronous reset
// Notes:   Types live in lsd_pkg
//
// What this block does
// - After reset the device runs in normal mode until a switch selects special.
// - Gate sampled high, low, high on successive edges starts a mode switch.
// - The mode-switching phase lasts two clock periods, then the new mode applies.
// - Fourth edge samples latch strobe: high picks special, low picks normal.
// - Strobe between third and fifth edges only picks mode, latches no data.
// - The low cycle of the switch pulse still enables the sink channels.
// - Shifting from serial input to serial output continues during mode switching.
// - Normal mode shifts serial input through the register to serial output.
// - Normal mode: high strobe copies shift register into the output latch.
// - Normal mode: low gate enables drivers for each set output latch bit.
// - Special mode with gate not low shifts serially exactly like normal mode.
// - Special mode: low gate starts error detection and enables the sinks.
// - After the second low sample the register input becomes error status bits.
// - Third and later low samples load error status into the register.
// - Special mode with gate low ignores serial input, shifts nothing in.
// - Gate high again restores serial shifting, ends detection, shifts status out.
// - Special mode: high strobe copies shift register into configuration latch.
// - Configuration latch holds its code until reset or a new write.
// - Multiplier bit gives ratio 15 when 1, 5 when 0; resets to 1.
// - Code: bit 0 multiplier, bit 1 band, bits 2 to 7 mantissa, all reset 1.
// - Status bit is 1 for enabled channel at threshold, else 0.
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH
`define LSD_CHANNELS     8
`define LSD_CFG_RESET    8'hff
`define LSD_GAIN_RESET   8'hfe
`define LSD_OUT_RESET    8'h00
`define LSD_CFG_MUL_BIT  0
`define LSD_CFG_BAND_BIT 1
`define LSD_CFG_MAN_LSB  2
`define LSD_CFG_MAN_MSB  7
`define LSD_RATIO_HIGH   5'h0f
`define LSD_RATIO_LOW    5'h05
`define LSD_CAPTURE_LOWS 2'h2
`define LSD_LOW_CNT_MAX  2'h3
`endif

// ===== rtl/lsd_pkg.sv
// Purpose: Types for the LED sink driver serial control logic
// Assumes: Included constants header
// Notes:   Mode encoding
package lsd_pkg;
  typedef enum logic [1:0] {
    LSD_NORMAL  = 2'b00,
    LSD_SWITCH  = 2'b01,
    LSD_SPECIAL = 2'b10
  } lsd_mode_t;
endpackage : lsd_pkg

// ===== rtl/lsd_sync.sv
// Purpose: Two-stage synchroniser for one pin
// Assumes: Reset value given by parameter
// Notes:   First stage read only by the second
`timescale 1ns/10ps
`default_nettype none
module lsd_sync #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // Data
  input  wire logic d,
  output var  logic q
);
  logic meta;
  logic next_meta;
  logic next_q;
  always_comb begin
    next_meta = clk_en ? d : meta;
    next_q    = clk_en ? meta : q;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule : lsd_sync
`default_nettype wire

// ===== rtl/lsd_top.sv
// Purpose: Serial shift, output latch, error capture and configuration
// Assumes: Serial clock is clk_sys; pins synchronised here
// Notes:   Status bits arrive from the analog detector per channel
`timescale 1ns/10ps
`default_nettype none
`include "lsd_params.svh"
module lsd_top
  import lsd_pkg::*;
#(
  parameter int CH = `LSD_CHANNELS
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          clk_en,
  // Host pins
  input  wire logic          serial_in,
  input  wire logic          latch_strobe,
  input  wire logic          drive_gate_pin_b,
  output var  logic          serial_out,
  // Detector comparator results, one per channel
  input  wire logic [CH-1:0] threshold_met,
  // Analog side
  output var  logic [CH-1:0] sink_channel,
  output var  logic [7:0]    voltage_gain_code,
  output var  logic          multiplier_select_bit,
  output var  logic [4:0]    current_ratio,
  output var  logic          special_mode,
  output var  logic          detect_active
);
  lsd_gate_if gif ();
  logic          gate_s;
  logic          strobe_s;
  logic          serial_s;
  logic [CH-1:0] thr_s;
  logic [CH-1:0] shreg;
  logic [CH-1:0] next_shreg;
  logic [CH-1:0] out_latch;
  logic [CH-1:0] next_out_latch;
  logic [7:0]    cfg;
  logic [7:0]    next_cfg;
  logic [1:0]    low_cnt;
  logic [1:0]    next_low_cnt;
  logic [CH-1:0] status;
  logic [CH-1:0] next_sink;
  logic          next_serial_out;
  logic          next_detect;
  logic [4:0]    next_ratio;

  lsd_sync #(.INIT(1'b1)) u_gate (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .d       (drive_gate_pin_b),
    .q       (gate_s)
  );
  lsd_sync #(.INIT(1'b0)) u_strobe (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .d       (latch_strobe),
    .q       (strobe_s)
  );
  // Data pin delayed like the gate and strobe pins to keep them aligned
  lsd_sync #(.INIT(1'b0)) u_data (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .d       (serial_in),
    .q       (serial_s)
  );

  // Per-channel synchroniser and status forming
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      lsd_sync #(.INIT(1'b0)) u_thr (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .d       (threshold_met[g]),
        .q       (thr_s[g])
      );
      assign status[g] = out_latch[g] & thr_s[g];
    end
  endgenerate

  lsd_mode u_mode (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .gate_s   (gate_s),
    .strobe_s (strobe_s),
    .gif      (gif)
  );

  always_comb begin
    next_shreg     = shreg;
    next_out_latch = out_latch;
    next_cfg       = cfg;
    next_low_cnt   = low_cnt;
    next_serial_out = serial_out;
    if (clk_en) begin
      // Count consecutive low gate samples in special mode
      if (gif.special && gif.gate_low) begin
        if (low_cnt != `LSD_LOW_CNT_MAX) begin
          next_low_cnt = low_cnt + 2'h1;
        end
      end else begin
        next_low_cnt = 2'h0;
      end
      if (gif.special && gif.gate_low) begin
        // Serial input ignored while detecting
        if (low_cnt >= `LSD_CAPTURE_LOWS) begin
          next_shreg = status;
        end
      end else begin
        next_shreg = {shreg[CH-2:0], serial_s};
        next_serial_out = shreg[CH-1];
      end
      if (gif.strobe && !gif.switching) begin
        if (gif.special) begin
          next_cfg = shreg[7:0];
        end else begin
          next_out_latch = shreg;
        end
      end
    end
  end

  always_comb begin
    next_sink   = gif.gate_low ? out_latch : '0;
    next_detect = gif.special & gif.gate_low;
    next_ratio  = next_cfg[`LSD_CFG_MUL_BIT] ? `LSD_RATIO_HIGH
                                             : `LSD_RATIO_LOW;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shreg       <= '0;
      out_latch   <= '0;
      cfg         <= `LSD_CFG_RESET;
      low_cnt     <= 2'h0;
      serial_out  <= 1'b0;
      sink_channel <= '0;
      voltage_gain_code <= `LSD_GAIN_RESET;
      multiplier_select_bit <= 1'b1;
      current_ratio <= `LSD_RATIO_HIGH;
      special_mode  <= 1'b0;
      detect_active <= 1'b0;
    end else begin
      shreg       <= next_shreg;
      out_latch   <= next_out_latch;
      cfg         <= next_cfg;
      low_cnt     <= next_low_cnt;
      serial_out  <= next_serial_out;
      if (clk_en) begin
        sink_channel <= next_sink;
        voltage_gain_code <= {next_cfg[`LSD_CFG_MAN_MSB:`LSD_CFG_MAN_LSB],
                              next_cfg[`LSD_CFG_BAND_BIT], 1'b0};
        multiplier_select_bit <= next_cfg[`LSD_CFG_MUL_BIT];
        current_ratio <= next_ratio;
        special_mode  <= gif.special;
        detect_active <= next_detect;
      end
    end
  end
endmodule : lsd_top
`default_nettype wire

// ===== sim/led_driver_shift_mode_control_bench.sv
// Purpose: Self-checking bench for lsd_top
// Assumes: Host model drives pins at falling edges
// Notes:   Status read back at a fixed offset after the gate rises
`timescale 1ns/10ps
`default_nettype none
module led_driver_shift_mode_control_bench;
  logic       clk_sys;
  logic       rst_b;
  logic       clk_en;
  logic       serial_in;
  logic       latch_strobe;
  logic       drive_gate_pin_b;
  logic       serial_out;
  logic [7:0] threshold_met;
  logic [7:0] sink_channel;
  logic [7:0] voltage_gain_code;
  logic       multiplier_select_bit;
  logic [4:0] current_ratio;
  logic       special_mode;
  logic       detect_active;
  int         failures;
  int         checks;
  lsd_host host (.clk_sys(clk_sys), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .drive_gate_pin_b(drive_gate_pin_b));
  lsd_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .serial_in(serial_in), .latch_strobe(latch_strobe),
    .drive_gate_pin_b(drive_gate_pin_b), .serial_out(serial_out),
    .threshold_met(threshold_met), .sink_channel(sink_channel),
    .voltage_gain_code(voltage_gain_code), .current_ratio(current_ratio),
    .multiplier_select_bit(multiplier_select_bit),
    .special_mode(special_mode), .detect_active(detect_active));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic t_normal();
    host.send_byte(8'ha5);
    host.strobe();
    host.gate(1'b0);
    host.cyc(6);
    chk(sink_channel, 8'ha5);
    host.gate(1'b1);
    host.cyc(6);
    chk(sink_channel, 8'h00);
  endtask : t_normal
  task automatic t_special();
    host.send_byte(8'h5a);
    host.switch_mode(1'b1);
    host.cyc(6);
    chk(8'(special_mode), 8'h01);
    chk(8'(multiplier_select_bit), 8'h01);
    host.send_byte(8'h3c);
    host.strobe();
    host.cyc(6);
    chk(8'(multiplier_select_bit), 8'h00);
    chk(8'(current_ratio), 8'h05);
    chk(voltage_gain_code, 8'h3c);
  endtask : t_special
  task automatic t_detect();
    logic [15:0] w;
    for (int k = 0; k < 2; k++) begin
      threshold_met = k ? 8'h25 : 8'h87;
      host.detect();
      chk(8'(detect_active), 8'h01);
      chk(sink_channel, 8'ha5);
      host.gate(1'b1);
      for (int i = 0; i < 16; i++) begin
        w = {w[14:0], serial_out};
        host.cyc(1);
      end
      chk(w[12:5], k ? 8'h25 : 8'h85);
      chk(8'(w[4:0]), 8'h00);
      chk(8'(detect_active), 8'h00);
    end
  endtask : t_detect
  task automatic t_back();
    host.switch_mode(1'b0);
    host.cyc(6);
    chk(8'(special_mode), 8'h00);
    chk(8'(multiplier_select_bit), 8'h00);
  endtask : t_back
  task automatic t_freeze();
    clk_en = 1'b0;
    host.send_byte(8'h0f);
    host.strobe();
    host.gate(1'b0);
    host.cyc(4);
    chk(sink_channel, 8'h00);
    clk_en = 1'b1;
    host.cyc(6);
    chk(sink_channel, 8'ha5);
    host.gate(1'b1);
    host.cyc(6);
    chk(sink_channel, 8'h00);
  endtask : t_freeze
  task automatic t_reset();
    rst_b = 1'b0;
    host.cyc(2);
    chk(voltage_gain_code, 8'hfe);
    chk(8'(multiplier_select_bit), 8'h01);
    rst_b = 1'b1;
    host.cyc(3);
    chk(8'(special_mode), 8'h00);
    chk(8'(current_ratio), 8'h0f);
  endtask : t_reset
  initial begin
    failures = 0;
    checks = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    threshold_met = 8'h00;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    host.cyc(3);
    chk(8'(special_mode), 8'h00);
    chk(voltage_gain_code, 8'hfe);
    chk(8'(current_ratio), 8'h0f);
    t_normal();
    t_special();
    t_detect();
    t_back();
    t_freeze();
    t_reset();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule : led_driver_shift_mode_control_bench
`default_nettype wire

// ===== sim/lsd_host.sv
// Purpose: Host controller model driving the serial pins
// Assumes: Tasks are entered at a falling clock edge
// Notes:   HOLD cycles at 20 ns exceed the status settle time
`timescale 1ns/10ps
`default_nettype none
module lsd_host #(
  parameter int HOLD = 104
) (
  // Clock
  input  wire logic clk_sys,
  // Host pins
  output var  logic serial_in,
  output var  logic latch_strobe,
  output var  logic drive_gate_pin_b
);
  initial begin
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    drive_gate_pin_b = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_in = b[i];
      cyc(1);
    end
    serial_in = 1'b0;
  endtask : send_byte
  task automatic strobe();
    latch_strobe = 1'b1;
    cyc(1);
    latch_strobe = 1'b0;
  endtask : strobe
  task automatic switch_mode(input logic sel);
    drive_gate_pin_b = 1'b0;
    cyc(1);
    drive_gate_pin_b = 1'b1;
    latch_strobe = sel;
    cyc(3);
    latch_strobe = 1'b0;
  endtask : switch_mode
  task automatic gate(input logic lvl);
    drive_gate_pin_b = lvl;
    serial_in = !lvl;
  endtask : gate
  task automatic detect();
    gate(1'b0);
    cyc(HOLD);
  endtask : detect
endmodule : lsd_host
`default_nettype wire

// ===== sim/lsd_monitor.sv
// Purpose: Port checker for lsd_top
// Assumes: One clock, rst_b active low
// Notes:   Bound to every lsd_top
`timescale 1ns/10ps
`default_nettype none
module lsd_monitor #(
  parameter int CH = 8
) (
  // Clock and reset
  input wire logic          clk_sys,
  input wire logic          rst_b,
  input wire logic          clk_en,
  // Host pins
  input wire logic          serial_in,
  input wire logic          latch_strobe,
  input wire logic          drive_gate_pin_b,
  input wire logic          serial_out,
  // Analog side
  input wire logic [CH-1:0] threshold_met,
  input wire logic [CH-1:0] sink_channel,
  input wire logic [7:0]    voltage_gain_code,
  input wire logic          multiplier_select_bit,
  input wire logic [4:0]    current_ratio,
  input wire logic          special_mode,
  input wire logic          detect_active
);
  logic [3:0] low_age;
  logic [3:0] next_low_age;
  logic       en_d;
  logic [3:0] run;
  logic [3:0] next_run;
  // Cycles since the gate was last seen low
  always_comb begin
    next_low_age = low_age;
    if (!drive_gate_pin_b)
      next_low_age = 4'h0;
    else if (low_age != 4'hf)
      next_low_age = low_age + 4'h1;
  end
  // Enabled shifting edges in a row, known one edge late
  always_comb begin
    next_run = 4'h0;
    if (en_d && !special_mode)
      next_run = (run == 4'hf) ? run : run + 4'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      low_age <= 4'hf;
      en_d    <= 1'b0;
      run     <= 4'h0;
    end else begin
      low_age <= next_low_age;
      en_d    <= clk_en;
      run     <= next_run;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_chain_full;
    run >= 4'ha && en_d && !special_mode;
  endsequence
  sequence s_quiet5;
    (!latch_strobe)[*5];
  endsequence
  a_ratio_tracks_mult: assert property (
    current_ratio == (multiplier_select_bit ? 5'h0f : 5'h05))
    else $error("ratio does not follow multiplier bit");
  a_mode_needs_pulse: assert property (
    $changed(special_mode) |-> low_age <= 4'ha)
    else $error("mode changed without gate pulse");
  a_sinks_off_high: assert property (
    low_age >= 4'h6 |-> sink_channel == '0)
    else $error("sinks on while gate high");
  a_detect_only_special: assert property (
    (!special_mode)[*4] |-> !detect_active)
    else $error("detection outside special mode");
  a_detect_on_low: assert property (
    (special_mode && !drive_gate_pin_b)[*5] |-> detect_active)
    else $error("no detection while gate low");
  a_detect_ends_high: assert property (
    detect_active |-> low_age <= 4'h4)
    else $error("detection kept after gate high");
  a_cfg_holds: assert property (
    s_quiet5 |-> $stable(multiplier_select_bit) && $stable(voltage_gain_code))
    else $error("configuration changed without strobe");
  a_serial_chain: assert property (
    s_chain_full |-> serial_out == $past(serial_in, 11))
    else $error("serial output not the delayed input");
endmodule : lsd_monitor
bind lsd_top lsd_monitor #(.CH(CH)) mon (.clk_sys(clk_sys), .rst_b(rst_b),
  .clk_en(clk_en), .serial_in(serial_in), .latch_strobe(latch_strobe),
  .drive_gate_pin_b(drive_gate_pin_b), .serial_out(serial_out),
  .threshold_met(threshold_met), .sink_channel(sink_channel),
  .voltage_gain_code(voltage_gain_code), .current_ratio(current_ratio),
  .multiplier_select_bit(multiplier_select_bit),
  .special_mode(special_mode), .detect_active(detect_active));
`default_nettype wire
